// *** design/pia_pkg.sv ***
/*
 * Shared constants, types and helpers of the priority interrupt arbiter.
 * Assumes one 50 MHz clock, an AHB-Lite master in front and a core behind.
 */
package pia_pkg;
    localparam int NUM_SRC = 82;
    localparam int SRC_W = 7;
    localparam int DATA_W = 16;
    localparam int PRIO_WORDS = 10;
    localparam int ENA_WORDS = 6;
    localparam int WIDE_SRC = ENA_WORDS * DATA_W;
    localparam int BANK_SRC = PRIO_WORDS * DATA_W / 2;
    localparam int VBA_W = 14;
    localparam int FVH_W = 5;
    localparam int ADDR_W = 21;
    localparam int IDX_W = 6;
    localparam int HADDR_LSB = 2;
    localparam int BUS_W = 32;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PRIO0 = 6'h00;
    localparam logic [IDX_W-1:0] IDX_VBA = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_FM0 = 6'h0B;
    localparam logic [IDX_W-1:0] IDX_FVL0 = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_FVH0 = 6'h0D;
    localparam logic [IDX_W-1:0] IDX_FM1 = 6'h0E;
    localparam logic [IDX_W-1:0] IDX_FVL1 = 6'h0F;
    localparam logic [IDX_W-1:0] IDX_FVH1 = 6'h10;
    localparam logic [IDX_W-1:0] IDX_PEND0 = 6'h11;
    localparam logic [IDX_W-1:0] IDX_ENA0 = 6'h18;
    localparam logic [IDX_W-1:0] IDX_CTL = 6'h1E;

    // Control register fields
    localparam int CTL_EDGE_A = 0;
    localparam int CTL_EDGE_B = 1;
    localparam int CTL_CODE_LO = 4;
    localparam int CTL_LP = 6;

    localparam logic [SRC_W-1:0] EXT_A_SRC = 7'h08;
    localparam logic [SRC_W-1:0] EXT_B_SRC = 7'h09;
    localparam logic [1:0] FAST_LEVEL = 2'h2;
    localparam logic [1:0] FIXED_LEVEL = 2'h3;
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [3:0] BOOT_HOLD = 4'h4;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_RD_WAIT = 3'b010,
        BUS_RD_LOAD = 3'b100
    } pia_bus_t;

    typedef struct packed {
        logic en;
        logic [IDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
    } pia_wr_t;

    typedef struct packed {
        logic fast;
        logic [SRC_W-1:0] num;
        logic [ADDR_W-1:0] addr;
    } pia_vec_t;

    // Lowest set position of a request vector, with a found flag
    function automatic logic [SRC_W:0] pia_first(input logic [NUM_SRC-1:0] v);
        logic [SRC_W:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = {1'b1, SRC_W'(i)};
            end
        end
        return r;
    endfunction

    // Level 0 -> 01, level 1 -> 10, levels 2 and 3 -> 11
    function automatic logic [1:0] pia_code_of(input logic [1:0] lvl);
        logic [1:0] c;
        c = (lvl == 2'h0) ? 2'h1 : ((lvl == 2'h1) ? 2'h2 : 2'h3);
        return c;
    endfunction
endpackage

// *** design/pia_prio_bank.sv ***
/*
 * Priority setting word store with a registered read port.
 * Assumes writes and reads come from the bus slave on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pia_prio_bank #(
    parameter int NWORDS = pia_pkg::PRIO_WORDS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire pia_pkg::pia_wr_t wr,
    input wire logic [pia_pkg::IDX_W-1:0] rd_idx,
    output logic [pia_pkg::DATA_W-1:0] rd_data,
    output logic [NWORDS*pia_pkg::DATA_W-1:0] flat
);
    typedef struct packed {
        logic [NWORDS*pia_pkg::DATA_W-1:0] mem;
        logic [pia_pkg::DATA_W-1:0] rdata;
    } pia_bank_state_t;

    pia_bank_state_t st_ff;
    pia_bank_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        for (int w = 0; w < NWORDS; w++)
        begin
            if (wr.en && (wr.idx == pia_pkg::IDX_W'(w)))
            begin
                nxt_st.mem[w*pia_pkg::DATA_W +: pia_pkg::DATA_W] = wr.data;
            end
            if (rd_idx == pia_pkg::IDX_W'(w))
            begin
                nxt_st.rdata = st_ff.mem[w*pia_pkg::DATA_W +: pia_pkg::DATA_W];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data = st_ff.rdata;
    assign flat = st_ff.mem;
endmodule // pia_prio_bank
`default_nettype wire

// *** design/pia_arbiter.sv ***
/*
 * Priority interrupt arbiter: AHB-Lite register slave, level arbitration,
 * vector generation with two fast slots, wake request for low power.
 * Assumes peripheral requests and core signals are on hclk; the two
 * external request pins are asynchronous and active low.
 */
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pia_arbiter #(
    parameter logic [pia_pkg::ADDR_W-1:0] BOOT_ADDR = 21'h000000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [pia_pkg::BUS_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [pia_pkg::BUS_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [pia_pkg::BUS_W-1:0] hrdata,
    output logic hresp,
    input wire logic [pia_pkg::NUM_SRC-1:0] periph_req,
    input wire logic ext_req_a_n,
    input wire logic ext_req_b_n,
    input wire logic [1:0] core_status_mask,
    input wire logic low_power_mode,
    input wire logic core_vector_ack,
    input wire logic core_return,
    output logic irq_to_core,
    output pia_pkg::pia_vec_t vector_out,
    output logic [1:0] current_priority_code,
    output logic wake_request,
    output logic boot_addr_drive
);
    typedef struct packed {
        pia_pkg::pia_bus_t bus;
        logic wr_pend;
        logic [pia_pkg::IDX_W-1:0] addr;
        logic readyout;
        logic [pia_pkg::BUS_W-1:0] rdata;
        logic resp;
        logic [pia_pkg::VBA_W-1:0] vector_base;
        logic [pia_pkg::SRC_W-1:0] fm0;
        logic [pia_pkg::DATA_W-1:0] fvl0;
        logic [pia_pkg::FVH_W-1:0] fvh0;
        logic [pia_pkg::SRC_W-1:0] fm1;
        logic [pia_pkg::DATA_W-1:0] fvl1;
        logic [pia_pkg::FVH_W-1:0] fvh1;
        logic [pia_pkg::WIDE_SRC-1:0] ena;
        logic [pia_pkg::NUM_SRC-1:0] lp_ena;
        logic lp_prev;
        logic edge_a;
        logic edge_b;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic filt_a;
        logic filt_b;
        logic lat_a;
        logic lat_b;
        logic [3:0] boot_cnt;
        logic boot;
        logic irq;
        pia_pkg::pia_vec_t vec;
        logic [1:0] vec_lvl;
        logic [1:0] code;
        logic wake;
    } pia_state_t;

    pia_state_t st_ff;
    pia_state_t nxt_st;
    pia_pkg::pia_wr_t bank_wr;
    logic [pia_pkg::DATA_W-1:0] bank_rdata;
    logic [pia_pkg::PRIO_WORDS*pia_pkg::DATA_W-1:0] prio_flat;
    logic ext_a_act;
    logic ext_b_act;
    logic [pia_pkg::NUM_SRC-1:0] raw_req;
    logic [pia_pkg::NUM_SRC-1:0] eff_req;
    logic [pia_pkg::WIDE_SRC-1:0] pend_wide;
    logic [1:0] src_lvl [pia_pkg::NUM_SRC];
    logic [pia_pkg::NUM_SRC-1:0] lvl_req [4];
    logic [pia_pkg::SRC_W:0] lvl_pick [4];
    logic [1:0] thr;
    logic sel_found;
    logic [pia_pkg::SRC_W-1:0] sel_num;
    logic [1:0] sel_lvl;
    logic hit0;
    logic hit1;
    logic addr_take;
    logic [pia_pkg::IDX_W-1:0] haddr_idx;
    logic [pia_pkg::IDX_W-1:0] ena_off;

    pia_prio_bank #(
        .NWORDS(pia_pkg::PRIO_WORDS)
    ) u_prio_bank (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr(bank_wr),
        .rd_idx(st_ff.addr),
        .rd_data(bank_rdata),
        .flat(prio_flat)
    );

    always_comb
    begin
        // External pins: edge latch only while the clock runs
        ext_a_act = (st_ff.edge_a && !low_power_mode) ? st_ff.lat_a : !st_ff.filt_a;
        ext_b_act = (st_ff.edge_b && !low_power_mode) ? st_ff.lat_b : !st_ff.filt_b;
        raw_req = periph_req;
        raw_req[pia_pkg::EXT_A_SRC] = ext_a_act;
        raw_req[pia_pkg::EXT_B_SRC] = ext_b_act;
        eff_req = raw_req & st_ff.ena[pia_pkg::NUM_SRC-1:0];
        pend_wide = '0;
        pend_wide[pia_pkg::NUM_SRC-1:0] = eff_req;

        // Sources past the bank carry a fixed level
        for (int s = 0; s < pia_pkg::NUM_SRC; s++)
        begin
            src_lvl[s] = (s < pia_pkg::BANK_SRC) ? prio_flat[2*s +: 2] : pia_pkg::FIXED_LEVEL;
        end
        for (int l = 0; l < 4; l++)
        begin
            for (int s = 0; s < pia_pkg::NUM_SRC; s++)
            begin
                lvl_req[l][s] = eff_req[s] && (src_lvl[s] == 2'(l));
            end
            lvl_pick[l] = pia_pkg::pia_first(lvl_req[l]);
        end

        // Mask and current code share one threshold scale
        thr = (core_status_mask > st_ff.code) ? core_status_mask : st_ff.code;
        sel_found = 1'b0;
        sel_num = '0;
        sel_lvl = '0;
        for (int l = 0; l < 4; l++)
        begin
            if (lvl_pick[l][pia_pkg::SRC_W] && (2'(l) >= thr))
            begin
                sel_found = 1'b1;
                sel_num = lvl_pick[l][pia_pkg::SRC_W-1:0];
                sel_lvl = 2'(l);
            end
        end
        hit0 = (sel_lvl == pia_pkg::FAST_LEVEL) && (sel_num == st_ff.fm0);
        hit1 = (sel_lvl == pia_pkg::FAST_LEVEL) && (sel_num == st_ff.fm1);

        haddr_idx = haddr[pia_pkg::HADDR_LSB +: pia_pkg::IDX_W];
        addr_take = hsel && hready && (htrans == pia_pkg::HTRANS_NONSEQ);
        ena_off = st_ff.addr - pia_pkg::IDX_ENA0;
        bank_wr.en = st_ff.wr_pend && (st_ff.addr < pia_pkg::IDX_VBA);
        bank_wr.idx = st_ff.addr;
        bank_wr.data = hwdata[pia_pkg::DATA_W-1:0];

        nxt_st = st_ff;

        // Three-stage pin synchronisers; change once stages two and three agree
        nxt_st.sync_a = {st_ff.sync_a[1:0], ext_req_a_n};
        nxt_st.sync_b = {st_ff.sync_b[1:0], ext_req_b_n};
        nxt_st.filt_a = (st_ff.sync_a[2] == st_ff.sync_a[1]) ? st_ff.sync_a[2] : st_ff.filt_a;
        nxt_st.filt_b = (st_ff.sync_b[2] == st_ff.sync_b[1]) ? st_ff.sync_b[2] : st_ff.filt_b;

        // Latched falling edges; a new edge beats the acknowledge clear
        nxt_st.lat_a = (st_ff.filt_a && !(|st_ff.sync_a[2:1])) ||
            (st_ff.lat_a && !(core_vector_ack && (st_ff.vec.num == pia_pkg::EXT_A_SRC)));
        nxt_st.lat_b = (st_ff.filt_b && !(|st_ff.sync_b[2:1])) ||
            (st_ff.lat_b && !(core_vector_ack && (st_ff.vec.num == pia_pkg::EXT_B_SRC)));

        // Enables frozen on entry to low power decide the wake
        nxt_st.lp_prev = low_power_mode;
        nxt_st.lp_ena = (low_power_mode && !st_ff.lp_prev) ?
            st_ff.ena[pia_pkg::NUM_SRC-1:0] : st_ff.lp_ena;
        nxt_st.wake = low_power_mode && st_ff.lp_prev && |(raw_req & st_ff.lp_ena);

        // Vector output; boot address holds for a few cycles after reset
        if (st_ff.boot)
        begin
            nxt_st.boot_cnt = st_ff.boot_cnt + 4'h1;
            nxt_st.boot = (st_ff.boot_cnt != pia_pkg::BOOT_HOLD);
            nxt_st.vec.addr = BOOT_ADDR;
            nxt_st.irq = 1'b0;
        end
        else
        begin
            nxt_st.irq = sel_found;
            nxt_st.vec.num = sel_num;
            nxt_st.vec_lvl = sel_lvl;
            nxt_st.vec.fast = sel_found && (hit0 || hit1);
            nxt_st.vec.addr = hit0 ? {st_ff.fvh0, st_ff.fvl0} :
                (hit1 ? {st_ff.fvh1, st_ff.fvl1} : {st_ff.vector_base, sel_num});
        end

        // Single level tracking: no nesting stack, return drops to none
        if (core_return)
        begin
            nxt_st.code = pia_pkg::CODE_NONE;
        end
        if (core_vector_ack && st_ff.irq)
        begin
            nxt_st.code = pia_pkg::pia_code_of(st_ff.vec_lvl);
        end

        // Bus slave: writes in a zero-wait data phase, reads with two waits
        nxt_st.wr_pend = 1'b0;
        unique case (st_ff.bus)
            pia_pkg::BUS_IDLE:
            begin
                if (st_ff.wr_pend)
                begin
                    unique case (st_ff.addr)
                        pia_pkg::IDX_VBA: nxt_st.vector_base = hwdata[pia_pkg::VBA_W-1:0];
                        pia_pkg::IDX_FM0: nxt_st.fm0 = hwdata[pia_pkg::SRC_W-1:0];
                        pia_pkg::IDX_FVL0: nxt_st.fvl0 = hwdata[pia_pkg::DATA_W-1:0];
                        pia_pkg::IDX_FVH0: nxt_st.fvh0 = hwdata[pia_pkg::FVH_W-1:0];
                        pia_pkg::IDX_FM1: nxt_st.fm1 = hwdata[pia_pkg::SRC_W-1:0];
                        pia_pkg::IDX_FVL1: nxt_st.fvl1 = hwdata[pia_pkg::DATA_W-1:0];
                        pia_pkg::IDX_FVH1: nxt_st.fvh1 = hwdata[pia_pkg::FVH_W-1:0];
                        pia_pkg::IDX_CTL:
                        begin
                            nxt_st.edge_a = hwdata[pia_pkg::CTL_EDGE_A];
                            nxt_st.edge_b = hwdata[pia_pkg::CTL_EDGE_B];
                        end
                        default:
                        begin
                            for (int w = 0; w < pia_pkg::ENA_WORDS; w++)
                            begin
                                if (ena_off == pia_pkg::IDX_W'(w))
                                begin
                                    nxt_st.ena[w*pia_pkg::DATA_W +: pia_pkg::DATA_W] =
                                        hwdata[pia_pkg::DATA_W-1:0];
                                end
                            end
                            nxt_st.ena[pia_pkg::WIDE_SRC-1:pia_pkg::NUM_SRC] = '0;
                        end
                    endcase
                end
                if (addr_take)
                begin
                    nxt_st.addr = haddr_idx;
                    nxt_st.wr_pend = hwrite && (hsize == pia_pkg::HSIZE_WORD);
                    if (!hwrite)
                    begin
                        nxt_st.bus = pia_pkg::BUS_RD_WAIT;
                        nxt_st.readyout = 1'b0;
                    end
                end
            end
            pia_pkg::BUS_RD_WAIT:
            begin
                nxt_st.bus = pia_pkg::BUS_RD_LOAD;
            end
            pia_pkg::BUS_RD_LOAD:
            begin
                nxt_st.bus = pia_pkg::BUS_IDLE;
                nxt_st.readyout = 1'b1;
                nxt_st.rdata = '0;
                if (st_ff.addr < pia_pkg::IDX_VBA)
                begin
                    nxt_st.rdata[pia_pkg::DATA_W-1:0] = bank_rdata;
                end
                else if (st_ff.addr >= pia_pkg::IDX_PEND0 && st_ff.addr < pia_pkg::IDX_PEND0 +
                         pia_pkg::IDX_W'(pia_pkg::ENA_WORDS))
                begin
                    nxt_st.rdata[pia_pkg::DATA_W-1:0] = pend_wide[
                        (st_ff.addr - pia_pkg::IDX_PEND0) * pia_pkg::DATA_W +: pia_pkg::DATA_W];
                end
                else if (st_ff.addr >= pia_pkg::IDX_ENA0 && st_ff.addr < pia_pkg::IDX_CTL)
                begin
                    nxt_st.rdata[pia_pkg::DATA_W-1:0] =
                        st_ff.ena[ena_off * pia_pkg::DATA_W +: pia_pkg::DATA_W];
                end
                else
                begin
                    unique case (st_ff.addr)
                        pia_pkg::IDX_VBA: nxt_st.rdata[pia_pkg::VBA_W-1:0] = st_ff.vector_base;
                        pia_pkg::IDX_FM0: nxt_st.rdata[pia_pkg::SRC_W-1:0] = st_ff.fm0;
                        pia_pkg::IDX_FVL0: nxt_st.rdata[pia_pkg::DATA_W-1:0] = st_ff.fvl0;
                        pia_pkg::IDX_FVH0: nxt_st.rdata[pia_pkg::FVH_W-1:0] = st_ff.fvh0;
                        pia_pkg::IDX_FM1: nxt_st.rdata[pia_pkg::SRC_W-1:0] = st_ff.fm1;
                        pia_pkg::IDX_FVL1: nxt_st.rdata[pia_pkg::DATA_W-1:0] = st_ff.fvl1;
                        pia_pkg::IDX_FVH1: nxt_st.rdata[pia_pkg::FVH_W-1:0] = st_ff.fvh1;
                        pia_pkg::IDX_CTL:
                        begin
                            nxt_st.rdata[pia_pkg::CTL_EDGE_A] = st_ff.edge_a;
                            nxt_st.rdata[pia_pkg::CTL_EDGE_B] = st_ff.edge_b;
                            nxt_st.rdata[pia_pkg::CTL_CODE_LO +: 2] = st_ff.code;
                            nxt_st.rdata[pia_pkg::CTL_LP] = st_ff.lp_prev;
                        end
                        default: nxt_st.rdata = '0;
                    endcase
                end
            end
            default:
            begin
                nxt_st.bus = pia_pkg::BUS_IDLE;
                nxt_st.readyout = 1'b1;
            end
        endcase
        nxt_st.resp = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
            st_ff.bus <= pia_pkg::BUS_IDLE;
            st_ff.readyout <= 1'b1;
            st_ff.sync_a <= 3'h7;
            st_ff.sync_b <= 3'h7;
            st_ff.filt_a <= 1'b1;
            st_ff.filt_b <= 1'b1;
            st_ff.boot <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout = st_ff.readyout;
    assign hrdata = st_ff.rdata;
    assign hresp = st_ff.resp;
    assign irq_to_core = st_ff.irq;
    assign vector_out = st_ff.vec;
    assign current_priority_code = st_ff.code;
    assign wake_request = st_ff.wake;
    assign boot_addr_drive = st_ff.boot;
endmodule // pia_arbiter
`default_nettype wire

// *** tb/pia_arbiter_chk.sv ***
/*
 * Port assertions of the arbiter, bound to it.
 * Assumes one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pia_arbiter_chk #(
    parameter logic [pia_pkg::ADDR_W-1:0] BOOT_ADDR = 21'h000000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq_to_core,
    input wire pia_pkg::pia_vec_t vector_out,
    input wire logic [1:0] current_priority_code,
    input wire logic core_vector_ack,
    input wire logic core_return,
    input wire logic boot_addr_drive
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_req;
        hsel && hready && htrans == pia_pkg::HTRANS_NONSEQ;
    endsequence
    sequence s_rd_wait;
        !hreadyout [*2] ##1 hreadyout;
    endsequence
    property p_rd_wait;
        s_req and !hwrite |=> s_rd_wait;
    endproperty
    property p_wr_fast;
        s_req and hwrite |=> hreadyout;
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_boot_hold;
        $rose(hresetn) |-> boot_addr_drive [*4];
    endproperty
    property p_boot_addr;
        boot_addr_drive && !$rose(hresetn) |-> vector_out.addr == BOOT_ADDR;
    endproperty
    property p_no_irq_in_boot;
        boot_addr_drive |-> !irq_to_core;
    endproperty
    property p_norm_vec;
        irq_to_core && !vector_out.fast |-> vector_out.addr[6:0] == vector_out.num;
    endproperty
    property p_code_cause;
        $changed(current_priority_code) |-> $past(core_vector_ack || core_return);
    endproperty
    property p_ret_clear;
        core_return && !core_vector_ack |=> current_priority_code == pia_pkg::CODE_NONE;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    a_okay: assert property (p_okay) else $error("response not okay");
    a_boot_hold: assert property (p_boot_hold) else $error("boot too short");
    a_boot_addr: assert property (p_boot_addr) else $error("boot addr wrong");
    a_no_irq_in_boot: assert property (p_no_irq_in_boot) else $error("irq in boot");
    a_norm_vec: assert property (p_norm_vec) else $error("vector low bits");
    a_code_cause: assert property (p_code_cause) else $error("code moved alone");
    a_ret_clear: assert property (p_ret_clear) else $error("code not cleared");
endmodule // pia_arbiter_chk

bind pia_arbiter pia_arbiter_chk #(.BOOT_ADDR(BOOT_ADDR)) chk_u (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .irq_to_core, .vector_out, .current_priority_code, .core_vector_ack,
    .core_return, .boot_addr_drive
);
`default_nettype wire

// *** tb/pia_core_model.sv ***
/*
 * Core model: mask, vector take, handler return.
 * Assumes bench commands change after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pia_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_to_core,
    input wire logic [1:0] mask_cmd,
    input wire logic ack_cmd,
    input wire logic ret_cmd,
    input wire logic [1:0] ack_dly,
    output logic [1:0] core_status_mask,
    output logic core_vector_ack,
    output logic core_return
);
    logic [1:0] wait_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wait_ff <= 2'h0;
            core_status_mask <= 2'h0;
            core_vector_ack <= 1'b0;
            core_return <= 1'b0;
        end
        else
        begin
            core_status_mask <= mask_cmd;
            core_return <= ret_cmd && !core_return;
            core_vector_ack <= 1'b0;
            // Delay mimics a busy core
            if (ack_cmd && irq_to_core && !core_vector_ack)
            begin
                wait_ff <= wait_ff + 2'h1;
                if (wait_ff == ack_dly)
                begin
                    core_vector_ack <= 1'b1;
                    wait_ff <= 2'h0;
                end
            end
        end
    end
endmodule // pia_core_model
`default_nettype wire

// *** tb/priority_interrupt_arbiter_tb.sv ***
/*
 * Bench: registers, arbitration, fast slots, codes, wake.
 * Assumes it is the sole bus master.
 */
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_arbiter_tb;
    logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, ext_req_a_n, ext_req_b_n;
    logic low_power_mode, core_vector_ack, core_return, irq_to_core, wake_request;
    logic boot_addr_drive, ack_cmd, ret_cmd;
    logic [1:0] htrans, core_status_mask, current_priority_code, mask_cmd, ack_dly, lv;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, seed, v, r;
    logic [81:0] periph_req;
    logic [159:0] pr;
    logic [95:0] en;
    logic [13:0] vector_base;
    logic [6:0] s1, s2, s3;
    pia_pkg::pia_vec_t vector_out;
    int n_errors, cmp_count;
    pia_arbiter #(.BOOT_ADDR(21'h12345)) dut_u (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
        .hresp, .periph_req, .ext_req_a_n, .ext_req_b_n, .core_status_mask,
        .low_power_mode, .core_vector_ack, .core_return, .irq_to_core, .vector_out,
        .current_priority_code, .wake_request, .boot_addr_drive);
    pia_core_model core_u (.hclk, .hresetn, .irq_to_core, .mask_cmd, .ack_cmd,
        .ret_cmd, .ack_dly, .core_status_mask, .core_vector_ack, .core_return);
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] ecode(input logic [1:0] l);
        return (l == 2'h0) ? 2'h1 : ((l == 2'h1) ? 2'h2 : 2'h3);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Each phase held until hready seen high; only the watchdog ends a wait
    task automatic bus(input logic w, input int idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= pia_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= 32'(idx * 4);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic push();
        for (int i = 0; i < 10; i++)
            bus(1'b1, i, {16'h0, pr[16*i +: 16]});
        for (int i = 0; i < 6; i++)
            bus(1'b1, pia_pkg::IDX_ENA0 + i, {16'h0, en[16*i +: 16]});
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_errors++;
        complete_run();
    end
    initial
    begin
        seed = 32'h87E939E5;
        n_errors = 0;
        cmp_count = 0;
        {hresetn, hsel, hwrite, ack_cmd, ret_cmd, low_power_mode, htrans, mask_cmd} <= '0;
        {ack_dly, haddr, hwdata, periph_req} <= '0;
        {ext_req_a_n, ext_req_b_n} <= 2'h3;
        hsize <= pia_pkg::HSIZE_WORD;
        repeat (5) @(posedge hclk);
        chk(boot_addr_drive, 1);
        hresetn <= 1'b1;
        bus(1'b0, pia_pkg::IDX_VBA, 0);
        chk(r, 0);
        v = xs();
        vector_base = v[13:0];
        bus(1'b1, pia_pkg::IDX_VBA, {18'h0, vector_base});
        bus(1'b0, pia_pkg::IDX_VBA, 0);
        chk(r, {18'h0, vector_base});
        bus(1'b1, 6'h17, 32'h0000FFFF);
        bus(1'b0, 6'h17, 0);
        chk(r, 0);
        repeat (20)
        begin
            v = xs();
            s1 = 7'(10 + v[7:0] % 40);
            s2 = s1 + 7'(1 + v[15:8] % 30);
            s3 = 7'(v[18:16]);
            lv = v[21:20];
            {pr, en} = '0;
            pr[2*s1 +: 2] = lv;
            pr[2*s2 +: 2] = lv;
            pr[2*s3 +: 2] = lv - 2'h1;
            {en[s1], en[s2], en[s3]} = {2'h3, lv != 2'h0};
            mask_cmd <= v[25:24];
            push();
            periph_req <= en[81:0];
            repeat (4) @(posedge hclk);
            chk(irq_to_core, lv >= v[25:24]);
            if (irq_to_core === 1'b1)
            begin
                chk(vector_out.num, s1);
                chk(vector_out.addr, {vector_base, s1});
                ack_dly <= v[29:28];
                ack_cmd <= 1'b1;
                repeat (20) if (core_vector_ack !== 1'b1) @(posedge hclk);
                ack_cmd <= 1'b0;
                repeat (2) @(posedge hclk);
                chk(current_priority_code, ecode(lv));
                ret_cmd <= 1'b1;
                @(posedge hclk);
                ret_cmd <= 1'b0;
                repeat (2) @(posedge hclk);
                chk(current_priority_code, 0);
            end
            periph_req <= '0;
        end
        mask_cmd <= 2'h0;
        for (int j = 0; j < 4; j++)
        begin
            v = xs();
            s1 = 7'(10 + v[7:0] % 70);
            lv = j[1] ? pia_pkg::FAST_LEVEL : 2'h1;
            {pr, en} = '0;
            pr[2*s1 +: 2] = lv;
            en[s1] = 1'b1;
            bus(1'b1, pia_pkg::IDX_FM0 + 3 * j[0], {25'h0, s1});
            bus(1'b1, pia_pkg::IDX_FVL0 + 3 * j[0], {16'h0, v[31:16]});
            bus(1'b1, pia_pkg::IDX_FVH0 + 3 * j[0], {27'h0, v[12:8]});
            push();
            periph_req <= en[81:0];
            repeat (4) @(posedge hclk);
            chk(vector_out.fast, j[1]);
            chk(vector_out.addr, j[1] ? {v[12:8], v[31:16]} : {vector_base, s1});
            periph_req <= '0;
            bus(1'b1, pia_pkg::IDX_FM0 + 3 * j[0], 0);
        end
        {pr, en} = '0;
        en[20] = 1'b1;
        push();
        low_power_mode <= 1'b1;
        repeat (2) @(posedge hclk);
        periph_req[20] <= 1'b1;
        repeat (4) @(posedge hclk);
        chk(wake_request, 1);
        periph_req <= '0;
        low_power_mode <= 1'b0;
        en = '0;
        push();
        low_power_mode <= 1'b1;
        {en[20], en[8]} = 2'h3;
        push();
        periph_req[20] <= 1'b1;
        repeat (4) @(posedge hclk);
        chk(wake_request, 0);
        periph_req <= '0;
        low_power_mode <= 1'b0;
        bus(1'b1, pia_pkg::IDX_CTL, 1);
        low_power_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        ext_req_a_n <= 1'b0;
        repeat (8) @(posedge hclk);
        chk(wake_request, 1);
        complete_run();
    end
endmodule // priority_interrupt_arbiter_tb
`default_nettype wire
